// [cpd_pkg.sv]
// ==========================================================================
// shared constants and types for the cpu-to-pci address decoder
// ==========================================================================
package cpd_pkg;

    // ======================================================================
    // system address layout
    // ======================================================================
    localparam int SYS_AW        = 40;
    localparam int NODE_MSB      = 39;   // node field addr[39:36]
    localparam int NODE_LSB      = 36;
    localparam int HOSE_MSB      = 35;   // hose field addr[35:34]
    localparam int HOSE_LSB      = 34;
    localparam int REGION_MSB    = 33;   // region field addr[33:32]
    localparam int REGION_LSB    = 32;
    localparam logic [3:0] NODE_CODE_BASE = 4'h8; // node 4 at 80_0000_0000
    localparam logic [3:0] NODE_FIRST     = 4'h4;

    // regions inside one 16-gbyte hose window
    localparam logic [1:0] REGION_DENSE  = 2'h0;
    localparam logic [1:0] REGION_SPMEM  = 2'h1;
    localparam logic [1:0] REGION_SPIO   = 2'h2;
    localparam logic [1:0] REGION_CFGLOC = 2'h3;

    // ======================================================================
    // burst shapes and pci fields
    // ======================================================================
    localparam int LW_BITS       = 32;
    localparam int BLOCK_LW      = 8;    // 32-byte block of longwords
    localparam int DENSE_ALIGN   = 5;    // block offset bits dropped
    localparam int SPARSE_SHIFT  = 7;    // size encoding plus low bits
    localparam logic [3:0] CBE_ALL_ON  = 4'h0;
    localparam logic [3:0] CBE_ALL_OFF = 4'hF;
    localparam logic [31:0] CFG_ADDR_MASK = 32'h03FF_FFFF; // addr[31:26]=0

    typedef enum logic [1:0] {
        CPD_SP_MEM = 2'b00,
        CPD_SP_IO  = 2'b01,
        CPD_SP_CFG = 2'b10
    } cpd_space_e;

    // one pci data phase as driven toward the segments
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  cbe_n;
        logic [31:0] data;
        logic        write;
        cpd_space_e  space;
        logic        last;
    } cpd_phase_s;

endpackage

// [cpd_addr_decode.sv]
`timescale 1ns/100ps
// Functional notes
// - The decoder owns one 16-gbyte hose window giving four mappings of a single 4-gbyte pci space.
// - System addresses below 80_0000_0000 are memory and nodes 4 to 8 each own a 64-gbyte i/o region.
// - Each node region splits into four 16-gbyte hose windows picked by the top two offset bits.
// - Window quarters map to dense memory, sparse memory, sparse i/o, then config and local space.
// - One logical pci address space is presented regardless of physical segment.
// - Dense offsets map one-to-one onto pci memory with only aligned longwords and quadwords.
// - Dense writes burst all eight longwords, with enables off for longwords not in the mask.
// - Dense reads burst the whole 32-byte block and return all of it.
// - Sparse byte accesses select one lane by addr[6:5] with a single active enable.
// - Sparse word, tribyte and longword sizes drive their fixed enable patterns.
// - A sparse quadword makes two phases with all enables on, low longword first.
// - The low 512 mbytes of sparse memory map to the low 16 mbytes of pci memory.
// - Above that, the memory high address extension supplies pci address bits 31:27.
// - Sparse longword data passes unshifted between system and pci lanes.
// - Pci address bits 1:0 are always zero for linear incrementing bursts.
module cpd_addr_decode #(
    parameter logic [3:0] NODE_ID = 4'h4,   // i/o node 4..8 this adapter sits on
    parameter logic [1:0] HOSE_ID = 2'h0
) (
    input  wire logic                I_SYS_CLK,
    input  wire logic                I_RESET,
    input  wire logic                I_REQ_VALID,
    input  wire logic [39:0]         I_REQ_ADDR,
    input  wire logic                I_REQ_WRITE,
    input  wire logic [7:0]          I_REQ_MASK,
    input  wire logic [255:0]        I_REQ_DATA,
    input  wire logic [4:0]          I_MEM_HIGH_ADDRESS_EXTENSION,
    input  wire logic [4:0]          I_IO_HIGH_ADDRESS_EXTENSION,
    input  wire logic                I_PCI_READY,
    input  wire logic [31:0]         I_PCI_RDATA,
    output logic                     O_REQ_READY,
    output logic                     O_PCI_VALID,
    output cpd_pkg::cpd_phase_s      O_PCI_PHASE,
    output logic                     O_RSP_VALID,
    output logic [255:0]             O_RSP_DATA,
    output logic                     O_LOCAL_VALID,
    output logic                     O_LOCAL_WRITE,
    output logic [30:0]              O_LOCAL_OFFSET
);

    // ======================================================================
    // helpers
    // ======================================================================
    // enables from addr[6:3]; undefined codes still give a fixed value
    function automatic logic [3:0] sparse_cbe(input logic [3:0] a63);
        logic [3:0] r;
        r = cpd_pkg::CBE_ALL_OFF;
        unique case ({a63[1:0], a63[3:2]})            // {a4:3, a6:5}
            4'h0: r = 4'hE;
            4'h1: r = 4'hD;
            4'h2: r = 4'hB;
            4'h3: r = 4'h7;
            4'h4: r = 4'hC;
            4'h5: r = 4'h9;
            4'h6: r = 4'h3;
            4'h7: r = 4'h7;
            4'h8: r = 4'h8;
            4'h9: r = 4'h1;
            4'hA: r = 4'h3;
            4'hB: r = 4'h7;
            4'hC: r = cpd_pkg::CBE_ALL_ON;
            4'hD: r = 4'h1;
            4'hE: r = 4'h3;
            4'hF: r = cpd_pkg::CBE_ALL_ON;
        endcase
        return r;
    endfunction

    // drop the seven encoding and low bits; extension fills bits 31:27 above 512 mbytes
    function automatic logic [31:0] sparse_addr(input logic [31:0] a, input logic [4:0] ext);
        logic [4:0] hi;
        hi = (|a[31:29]) ? ext : 5'h00;
        return {hi, a[31:cpd_pkg::SPARSE_SHIFT], 2'b00};
    endfunction

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BURST = 2'b01,
        ST_RESP  = 2'b10
    } cpd_state_e;

    // ======================================================================
    // state
    // ======================================================================
    cpd_state_e          state_reg, state_next;
    logic [31:0]         base_reg, base_next;
    logic [2:0]          count_reg, count_next;
    logic [2:0]          lastc_reg, lastc_next;
    logic                dense_reg, dense_next;
    logic                write_reg, write_next;
    logic [7:0]          mask_reg, mask_next;
    logic [255:0]        data_reg, data_next;
    logic [3:0]          spcbe_reg, spcbe_next;
    cpd_pkg::cpd_space_e space_reg, space_next;
    logic                ready_reg, ready_next;
    logic                pvalid_reg, pvalid_next;
    cpd_pkg::cpd_phase_s phase_reg, phase_next;
    logic                rvalid_reg, rvalid_next;
    logic [255:0]        rdata_reg, rdata_next;
    logic                lvalid_reg, lvalid_next;
    logic                lwrite_reg, lwrite_next;
    logic [30:0]         loff_reg, loff_next;

    logic       take;
    logic       hit;
    logic [1:0] region;
    logic [31:0] off;

    // window match: node region then hose quarter
    assign take   = I_REQ_VALID & ready_reg;
    assign hit    = I_REQ_ADDR[cpd_pkg::NODE_MSB:cpd_pkg::NODE_LSB]
                    == NODE_ID - cpd_pkg::NODE_FIRST + cpd_pkg::NODE_CODE_BASE
                    && I_REQ_ADDR[cpd_pkg::HOSE_MSB:cpd_pkg::HOSE_LSB] == HOSE_ID;
    assign region = I_REQ_ADDR[cpd_pkg::REGION_MSB:cpd_pkg::REGION_LSB];
    assign off    = I_REQ_ADDR[31:0];

    // ======================================================================
    // next-state and phase generation
    // ======================================================================
    always_comb begin
        state_next  = state_reg;
        base_next   = base_reg;
        count_next  = count_reg;
        lastc_next  = lastc_reg;
        dense_next  = dense_reg;
        write_next  = write_reg;
        mask_next   = mask_reg;
        data_next   = data_reg;
        spcbe_next  = spcbe_reg;
        space_next  = space_reg;
        ready_next  = ready_reg;
        pvalid_next = pvalid_reg;
        rvalid_next = 1'b0;
        rdata_next  = rdata_reg;
        lvalid_next = 1'b0;
        lwrite_next = lwrite_reg;
        loff_next   = loff_reg;
        unique case (state_reg)
            ST_IDLE: begin
                // idle always offers a slot; this is also what raises ready after reset
                ready_next = 1'b1;
                // misses are swallowed: other adapters own those addresses
                if (take && hit) begin
                    write_next = I_REQ_WRITE;
                    mask_next  = I_REQ_MASK;
                    data_next  = I_REQ_DATA;
                    count_next = 3'h0;
                    dense_next = 1'b0;
                    spcbe_next = sparse_cbe(off[6:3]);
                    lastc_next = (&off[6:3]) ? 3'h1 : 3'h0;
                    // same pci address for all segments; one logical space
                    unique case (region)
                        cpd_pkg::REGION_DENSE: begin
                            base_next  = {off[31:cpd_pkg::DENSE_ALIGN], 5'h00};
                            dense_next = 1'b1;
                            lastc_next = 3'(cpd_pkg::BLOCK_LW - 1);
                            space_next = cpd_pkg::CPD_SP_MEM;
                        end
                        cpd_pkg::REGION_SPMEM: begin
                            base_next  = sparse_addr(off, I_MEM_HIGH_ADDRESS_EXTENSION);
                            space_next = cpd_pkg::CPD_SP_MEM;
                        end
                        cpd_pkg::REGION_SPIO: begin
                            base_next  = sparse_addr(off, I_IO_HIGH_ADDRESS_EXTENSION);
                            space_next = cpd_pkg::CPD_SP_IO;
                        end
                        cpd_pkg::REGION_CFGLOC: begin
                            base_next  = sparse_addr(off, 5'h00) & cpd_pkg::CFG_ADDR_MASK;
                            space_next = cpd_pkg::CPD_SP_CFG;
                        end
                    endcase
                    if (region == cpd_pkg::REGION_CFGLOC && off[31]) begin
                        // local registers and map ram never reach the pci
                        lvalid_next = 1'b1;
                        lwrite_next = I_REQ_WRITE;
                        loff_next   = off[30:0];
                    end else begin
                        state_next  = ST_BURST;
                        ready_next  = 1'b0;
                        pvalid_next = 1'b1;
                        rdata_next  = '0;
                    end
                end
            end
            ST_BURST: begin
                if (I_PCI_READY) begin
                    if (!write_reg) begin
                        rdata_next[count_reg*cpd_pkg::LW_BITS +: cpd_pkg::LW_BITS] = I_PCI_RDATA;
                    end
                    if (count_reg == lastc_reg) begin
                        pvalid_next = 1'b0;
                        state_next  = write_reg ? ST_IDLE : ST_RESP;
                        ready_next  = write_reg;
                        rvalid_next = !write_reg;
                    end else begin
                        count_next = count_reg + 3'h1;
                    end
                end
            end
            ST_RESP: begin
                state_next = ST_IDLE;
                ready_next = 1'b1;
            end
            default: begin
                state_next  = ST_IDLE;
                ready_next  = 1'b1;
                pvalid_next = 1'b0;
            end
        endcase
        // phase contents from the next count so the output is a flop
        phase_next.addr  = base_next + {27'h000_0000, count_next, 2'b00};
        phase_next.cbe_n = dense_next
                           ? ((write_next && !mask_next[count_next]) ? cpd_pkg::CBE_ALL_OFF
                                                                      : cpd_pkg::CBE_ALL_ON)
                           : spcbe_next;
        phase_next.data  = data_next[count_next*cpd_pkg::LW_BITS +: cpd_pkg::LW_BITS];
        phase_next.write = write_next;
        phase_next.space = space_next;
        phase_next.last  = (count_next == lastc_next);
    end

    // ======================================================================
    // registers
    // ======================================================================
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            state_reg  <= ST_IDLE;
            base_reg   <= 32'h0000_0000;
            count_reg  <= 3'h0;
            lastc_reg  <= 3'h0;
            dense_reg  <= 1'b0;
            write_reg  <= 1'b0;
            mask_reg   <= 8'h00;
            data_reg   <= '0;
            spcbe_reg  <= cpd_pkg::CBE_ALL_OFF;
            space_reg  <= cpd_pkg::CPD_SP_MEM;
            ready_reg  <= 1'b0;
            pvalid_reg <= 1'b0;
            phase_reg  <= '0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            lvalid_reg <= 1'b0;
            lwrite_reg <= 1'b0;
            loff_reg   <= 31'h0000_0000;
        end else begin
            state_reg  <= state_next;
            base_reg   <= base_next;
            count_reg  <= count_next;
            lastc_reg  <= lastc_next;
            dense_reg  <= dense_next;
            write_reg  <= write_next;
            mask_reg   <= mask_next;
            data_reg   <= data_next;
            spcbe_reg  <= spcbe_next;
            space_reg  <= space_next;
            ready_reg  <= ready_next;
            pvalid_reg <= pvalid_next;
            phase_reg  <= phase_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            lvalid_reg <= lvalid_next;
            lwrite_reg <= lwrite_next;
            loff_reg   <= loff_next;
        end
    end

    // outputs straight from flops
    assign O_REQ_READY    = ready_reg;
    assign O_PCI_VALID    = pvalid_reg;
    assign O_PCI_PHASE    = phase_reg;
    assign O_RSP_VALID    = rvalid_reg;
    assign O_RSP_DATA     = rdata_reg;
    assign O_LOCAL_VALID  = lvalid_reg;
    assign O_LOCAL_WRITE  = lwrite_reg;
    assign O_LOCAL_OFFSET = loff_reg;

    // ======================================================================
    // assertions
    // ======================================================================
    property p_low_bits_zero;
        @(posedge I_SYS_CLK) disable iff (I_RESET) O_PCI_VALID |-> O_PCI_PHASE.addr[1:0] == 2'b00;
    endproperty
    a_low_bits_zero: assert property (p_low_bits_zero) else $error("pci addr low bits nonzero");

    property p_miss_ignored;
        @(posedge I_SYS_CLK) disable iff (I_RESET) (take && !hit) |=> (!O_PCI_VALID && !O_LOCAL_VALID);
    endproperty
    a_miss_ignored: assert property (p_miss_ignored) else $error("foreign address acted on");

    property p_dense_aligned;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (take && hit && region == cpd_pkg::REGION_DENSE)
            |=> O_PCI_VALID && O_PCI_PHASE.addr == {$past(off[31:5]), 5'h00};
    endproperty
    a_dense_aligned: assert property (p_dense_aligned) else $error("dense base wrong");

    property p_dense_len;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (O_PCI_VALID && O_PCI_PHASE.last && dense_reg) |-> count_reg == 3'h7;
    endproperty
    a_dense_len: assert property (p_dense_len) else $error("dense burst not eight phases");

    property p_read_resp;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (O_PCI_VALID && O_PCI_PHASE.last && !O_PCI_PHASE.write && I_PCI_READY) |=> O_RSP_VALID;
    endproperty
    a_read_resp: assert property (p_read_resp) else $error("read data not returned");

    property p_byte_lane;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (take && hit && region == cpd_pkg::REGION_SPMEM && off[4:3] == 2'b00)
            |=> $countones(O_PCI_PHASE.cbe_n) == 3 && O_PCI_PHASE.cbe_n[$past(off[6:5])] == 1'b0;
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte enable lane wrong");

    property p_longword;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (take && hit && region == cpd_pkg::REGION_SPMEM && off[6:3] == 4'h3)
            |=> O_PCI_PHASE.cbe_n == 4'h0 && O_PCI_PHASE.last;
    endproperty
    a_longword: assert property (p_longword) else $error("longword enables wrong");

    property p_quad;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (take && hit && region == cpd_pkg::REGION_SPMEM && off[6:3] == 4'hF)
            |=> !O_PCI_PHASE.last && O_PCI_PHASE.cbe_n == 4'h0;
    endproperty
    a_quad: assert property (p_quad) else $error("quadword not two phases");

    property p_low_window;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (take && hit && region == cpd_pkg::REGION_SPMEM && off[31:29] == 3'h0)
            |=> O_PCI_PHASE.addr[31:24] == 8'h00;
    endproperty
    a_low_window: assert property (p_low_window) else $error("low sparse window escapes");

    property p_ext;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (take && hit && region == cpd_pkg::REGION_SPMEM && off[31:29] != 3'h0)
            |=> O_PCI_PHASE.addr[31:27] == $past(I_MEM_HIGH_ADDRESS_EXTENSION);
    endproperty
    a_ext: assert property (p_ext) else $error("extension bits not used");

    property p_unshifted;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (take && hit && region == cpd_pkg::REGION_SPMEM && I_REQ_WRITE)
            |=> O_PCI_PHASE.data == $past(I_REQ_DATA[31:0]);
    endproperty
    a_unshifted: assert property (p_unshifted) else $error("sparse data shifted");

    property p_local;
        @(posedge I_SYS_CLK) disable iff (I_RESET)
            (take && hit && region == cpd_pkg::REGION_CFGLOC && off[31]) |=> O_LOCAL_VALID && !O_PCI_VALID;
    endproperty
    a_local: assert property (p_local) else $error("local access misrouted");

    c_dense_write: cover property (@(posedge I_SYS_CLK) O_PCI_VALID && dense_reg && write_reg && O_PCI_PHASE.last);
    c_dense_read: cover property (@(posedge I_SYS_CLK) O_RSP_VALID && dense_reg);
    c_quad: cover property (@(posedge I_SYS_CLK) O_PCI_VALID && !dense_reg && O_PCI_PHASE.last && count_reg == 3'h1);
    c_local: cover property (@(posedge I_SYS_CLK) O_LOCAL_VALID);

endmodule

// [cpd_pci_target.sv]
`timescale 1ns/100ps
// ==========================================================================
// far-side pci target: prompt or stalling, answers the whole logical space
// ==========================================================================
module cpd_pci_target (
    input  wire logic                i_sys_clk,
    input  wire logic                i_reset,
    input  wire logic                i_valid,
    input  wire cpd_pkg::cpd_phase_s i_phase,
    input  wire logic                i_slow,
    output logic                     o_ready,
    output logic [31:0]              o_rdata
);
    logic        go_reg;
    logic [31:0] junk_reg;

    // random stalls in slow mode; idle data keeps moving so stale values never match
    always_ff @(posedge i_sys_clk) begin
        go_reg   <= i_reset ? 1'b0 : (!i_slow || ($urandom % 3 == 0));
        junk_reg <= i_reset ? 32'h0000_0000 : junk_reg + 32'h1357_9BDF;
    end

    assign o_ready = i_valid && go_reg;
    // every longword of any block exists and reads without side effects
    assign o_rdata = (i_valid && !i_phase.write) ? (i_phase.addr ^ 32'hC3A5_0F1E) : junk_reg;
endmodule

// [test_cpd_addr_decode.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_cpd_addr_decode;
    localparam logic [3:0] NODE = 4'h5;
    localparam logic [1:0] HOSE = 2'h2;
    logic clk, rst, vld, wr, prdy, slow, pvld, rvld, lvld, lwr, qrdy;
    logic [39:0] addr;
    logic [7:0] mask, m;
    logic [255:0] data, rsp, d;
    logic [4:0] mext, iext;
    logic [31:0] rdata, o;
    logic [30:0] loff;
    logic [511:0] er;
    cpd_pkg::cpd_phase_s ph, e;
    cpd_pkg::cpd_phase_s exp_ph[$];
    logic [511:0] exp_rsp[$];
    logic [31:0] exp_loc[$];
    int n_errors = 0;
    int num_checks = 0;
    // enables by {size, lane}, undefined codes included
    logic [3:0] tbl[16] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h9, 4'h3, 4'h7,
                            4'h8, 4'h1, 4'h3, 4'h7, 4'h0, 4'h1, 4'h3, 4'h0};

    cpd_addr_decode #(.NODE_ID(NODE), .HOSE_ID(HOSE)) cpd_addr_decode_i (
        .I_SYS_CLK(clk), .I_RESET(rst), .I_REQ_VALID(vld), .I_REQ_ADDR(addr), .I_REQ_WRITE(wr),
        .I_REQ_MASK(mask), .I_REQ_DATA(data), .I_MEM_HIGH_ADDRESS_EXTENSION(mext),
        .I_IO_HIGH_ADDRESS_EXTENSION(iext), .I_PCI_READY(prdy), .I_PCI_RDATA(rdata),
        .O_REQ_READY(qrdy), .O_PCI_VALID(pvld), .O_PCI_PHASE(ph), .O_RSP_VALID(rvld),
        .O_RSP_DATA(rsp), .O_LOCAL_VALID(lvld), .O_LOCAL_WRITE(lwr), .O_LOCAL_OFFSET(loff));
    cpd_pci_target cpd_pci_target_i (.i_sys_clk(clk), .i_reset(rst), .i_valid(pvld), .i_phase(ph),
        .i_slow(slow), .o_ready(prdy), .o_rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict;
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // model the request, then hold it until the decoder takes it
    task automatic send(input logic [39:0] a, input logic w, input logic [7:0] mk, input logic [255:0] dt);
        cpd_pkg::cpd_phase_s p;
        logic [31:0] b;
        logic [511:0] r;
        logic [4:0] me, ie;
        int n;
        me = 5'($urandom);
        ie = 5'($urandom);
        p = '0;
        r = '0;
        p.write = w;
        n = (a[33:32] == 2'h0) ? 8 : ((a[6:3] == 4'hF) ? 2 : 1);
        b = (a[33:32] == 2'h0) ? {a[31:5], 5'h00} :
            {(a[31:29] == 3'h0) ? 5'h00 : (a[32] ? me : ie), a[31:7], 2'b00};
        if (a[33:32] == 2'h3) b = b & cpd_pkg::CFG_ADDR_MASK;
        p.space = (a[33:32] == 2'h2) ? cpd_pkg::CPD_SP_IO :
                  ((a[33:32] == 2'h3) ? cpd_pkg::CPD_SP_CFG : cpd_pkg::CPD_SP_MEM);
        if (a[39:36] == NODE + 4'h4 && a[35:34] == HOSE) begin
            if (a[33:32] == 2'h3 && a[31]) exp_loc.push_back({w, a[30:0]});
            else begin
                for (int i = 0; i < n; i++) begin
                    p.addr = b + 32'(4 * i);
                    p.cbe_n = (n == 8) ? ((w && !mk[i]) ? 4'hF : 4'h0) : tbl[{a[4:3], a[6:5]}];
                    p.data = dt[32*i +: 32];
                    p.last = (i == n - 1);
                    exp_ph.push_back(p);
                    r[256 + 32*i +: 32] = '1;
                    r[32*i +: 32] = p.addr ^ 32'hC3A5_0F1E;
                end
                if (!w) exp_rsp.push_back(r);
            end
        end
        @(posedge clk);
        vld <= 1'b1; addr <= a; wr <= w; mask <= mk; data <= dt; mext <= me; iext <= ie;
        n = 0;
        do begin @(posedge clk); n++; end while (qrdy !== 1'b1 && n < 100);
        vld <= 1'b0;
        `CHK(n < 100, 1'b1)
        if (n >= 100) give_verdict();
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            if (n > 2 && qrdy && exp_ph.size() == 0 && exp_rsp.size() == 0 && exp_loc.size() == 0) break;
        end
        `CHK(n < 300, 1'b1)
        if (n >= 300) give_verdict();
    endtask

    // compare every accepted phase, response and local access with the model
    always @(posedge clk) begin
        if (pvld && prdy) begin
            `CHK(exp_ph.size() > 0, 1'b1)
            if (exp_ph.size() > 0) begin
                e = exp_ph.pop_front();
                `CHK({ph.addr, ph.cbe_n, ph.write, ph.space, ph.last}, {e.addr, e.cbe_n, e.write, e.space, e.last})
                if (e.write) `CHK(ph.data, e.data)
                `CHK(ph.addr[1:0], 2'b00)
            end
        end
        if (rvld) begin
            `CHK(exp_rsp.size() > 0, 1'b1)
            if (exp_rsp.size() > 0) begin
                er = exp_rsp.pop_front();
                `CHK(rsp & er[511:256], er[255:0])
            end
        end
        if (lvld) begin
            `CHK(exp_loc.size() > 0, 1'b1)
            if (exp_loc.size() > 0) `CHK({lwr, loff}, exp_loc.pop_front())
        end
    end

    initial begin
        vld = 1'b0; rst = 1'b1; wr = 1'b0; mask = '0; data = '0; addr = '0; mext = '0; iext = '0; slow = 1'b0;
        void'($urandom(32'h38fa7e3d));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // every sparse code, both directions, in memory, i/o and config space
        for (int r = 1; r < 4; r++) for (int c = 0; c < 16; c++) for (int w = 0; w < 2; w++) begin
            o = $urandom;
            o[6:0] = {c[1:0], c[3:2], 3'b000};
            if (c == 15) o[7] = 1'b0;
            if (r == 3) o[31] = 1'b0;
            if (c < 4) o[31:29] = 3'h0;
            for (int i = 0; i < 8; i++) d[32*i +: 32] = $urandom;
            slow <= c[0];
            send({NODE + 4'h4, HOSE, 2'(r), o}, w[0], 8'h00, d);
        end
        // dense blocks: empty, full and random masks, then reads
        for (int k = 0; k < 6; k++) begin
            o = $urandom & 32'hFFFF_FFE0;
            m = (k == 0) ? 8'h00 : ((k == 1) ? 8'hFF : 8'($urandom));
            for (int i = 0; i < 8; i++) d[32*i +: 32] = $urandom;
            slow <= 1'b1;
            send({NODE + 4'h4, HOSE, 2'h0, o}, k < 4, m, d);
        end
        // misses: other node, other hose, system memory; then local accesses
        send({4'h8, HOSE, 2'h1, 32'h0000_0040}, 1'b1, 8'h00, d);
        send({NODE + 4'h4, HOSE + 2'h1, 2'h0, 32'h0000_0000}, 1'b0, 8'h00, d);
        send({4'h1, HOSE, 2'h0, 32'h0000_0000}, 1'b1, 8'hFF, d);
        for (int k = 0; k < 4; k++) send({NODE + 4'h4, HOSE, 2'h3, 32'($urandom) | 32'h8000_0000}, k[0], 8'h00, d);
        give_verdict();
    end
endmodule
